//--- bench/hbm_asserts.sv
// Checker for the peripheral bus pins of the host bus emulation master.
// Assumes binding to the top module; RST_I is the reset of its one domain.
`timescale 1ns/100ps
module hbm_asserts (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	// Bus pins
	input wire logic ACCESS_WAIT_IN_I,
	input wire logic [7:0] MUX_ADDR_DATA_BUS_O,
	input wire logic MUX_ADDR_DATA_BUS_OE_O,
	input wire logic [7:0] ADDR_HI_O,
	input wire logic SEL_N_O,
	input wire logic ADDR_LATCH_O,
	input wire logic RD_N_O,
	input wire logic WR_N_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	// High while neither strobe is active
	wire logic idle = RD_N_O & WR_N_O;
	sequence s_latch;
		ADDR_LATCH_O && MUX_ADDR_DATA_BUS_OE_O;
	endsequence
	sequence s_close;
		idle ##1 (SEL_N_O && !MUX_ADDR_DATA_BUS_OE_O);
	endsequence
	property p_ale;
		$rose(ADDR_LATCH_O) |-> s_latch [*2] ##1 !ADDR_LATCH_O;
	endproperty
	a_ale: assert property (p_ale) else $error("latch pulse wrong");
	property p_excl;
		!(!RD_N_O && !WR_N_O);
	endproperty
	a_excl: assert property (p_excl) else $error("both strobes low");
	property p_sel;
		!idle |-> !SEL_N_O;
	endproperty
	a_sel: assert property (p_sel) else $error("strobe without select");
	property p_order;
		$fell(SEL_N_O) |-> $past(ADDR_LATCH_O) && !ADDR_LATCH_O;
	endproperty
	a_order: assert property (p_order) else $error("select before latch");
	property p_hi;
		!SEL_N_O |-> $stable(ADDR_HI_O);
	endproperty
	a_hi: assert property (p_hi) else $error("upper address moved");
	property p_wdata;
		($fell(WR_N_O) || $rose(WR_N_O)) |->
			MUX_ADDR_DATA_BUS_OE_O && $stable(MUX_ADDR_DATA_BUS_O);
	endproperty
	a_wdata: assert property (p_wdata) else $error("write data moved");
	property p_rel;
		!RD_N_O |-> !MUX_ADDR_DATA_BUS_OE_O;
	endproperty
	a_rel: assert property (p_rel) else $error("bus driven in read");
	property p_min;
		$fell(idle) |-> !idle [*2];
	endproperty
	a_min: assert property (p_min) else $error("strobe too short");
	property p_wait;
		(!idle && !ACCESS_WAIT_IN_I) [*4] |=> !idle;
	endproperty
	a_wait: assert property (p_wait) else $error("wait ignored");
	property p_end;
		$rose(idle) |-> s_close;
	endproperty
	a_end: assert property (p_end) else $error("select not dropped");
endmodule
bind host_bus_emulation_master hbm_asserts u_chk (.CORE_CLK_I(CORE_CLK_I),
	.RST_I(RST_I), .ACCESS_WAIT_IN_I(ACCESS_WAIT_IN_I),
	.MUX_ADDR_DATA_BUS_O(MUX_ADDR_DATA_BUS_O),
	.MUX_ADDR_DATA_BUS_OE_O(MUX_ADDR_DATA_BUS_OE_O), .ADDR_HI_O(ADDR_HI_O),
	.SEL_N_O(SEL_N_O), .ADDR_LATCH_O(ADDR_LATCH_O), .RD_N_O(RD_N_O),
	.WR_N_O(WR_N_O));

//--- bench/hbm_periph_model.sv
// Peripheral chip model on the multiplexed address/data bus.
// Assumes the bench resolves the shared bus from the master's enable.
`timescale 1ns/100ps
module hbm_periph_model (
	// Clock and stall selection
	input wire logic clk_i,
	input wire logic slow_i,
	// Master side pins
	input wire logic [7:0] addr_hi_i,
	input wire logic [7:0] bus_i,
	input wire logic dev_oe_i,
	input wire logic sel_n_i,
	input wire logic ale_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	// Peripheral drive
	output logic [7:0] bus_o,
	output logic wait_n_o
);
	logic [7:0] mem [65536];
	logic [7:0] addr_lo_r = 8'h00;
	logic [7:0] last_r = 8'h00;
	logic [2:0] stall_r = 3'h0;
	logic ale_r = 1'b0;
	logic drive;
	// Drive from select onward so data is settled long before the strobe rises
	assign drive = !sel_n_i && wr_n_i && !dev_oe_i;
	// Released bus shows the inverse of the last value, never a stale copy
	assign bus_o = drive ? mem[{addr_hi_i, addr_lo_r}] : ~last_r;
	assign wait_n_o = (stall_r == 3'h0);
	// Address latch, write capture and access stretching
	always @(posedge clk_i) begin
		if (ale_i)
			addr_lo_r <= bus_i;
		if (!wr_n_i)
			mem[{addr_hi_i, addr_lo_r}] <= bus_i;
		if (drive)
			last_r <= bus_o;
		ale_r <= ale_i;
		// Stall from the latch pulse on: wait crosses two flops in the
		// master, so a stall raised only at the strobe would come too late
		if (ale_i && !ale_r && slow_i)
			stall_r <= 3'h6;
		else if (stall_r != 3'h0)
			stall_r <= stall_r - 3'h1;
	end
endmodule

//--- bench/host_bus_emulation_master_tb.sv
// Self-checking bench: host byte commands in, peripheral model on the bus.
// Assumes the opcodes and bus phases of the package; buffers shrunk to 16.
`timescale 1ns/100ps
module host_bus_emulation_master_tb;
	logic clk = 0, rst = 1, ext_n = 1, tx_v = 0, rx_rdy = 0, slow = 0;
	logic zero_ext = 0, wait_ext = 0;
	logic [7:0] tx_d = 8'h00;
	wire logic [7:0] bus_o, bus_i, dout, rx_d, ahi;
	wire logic oe, tx_rdy, rx_v, sel_n, ale, rd_n, wr_n, wait_n, ifclk;
	wire logic z_o, z_oe, w_o, w_oe, zi, wi;
	int miscompares = 0, cmp_count = 0, low_len = 0, max_low = 0;
	// Resolve shared bus and aux pins from the master's enables
	assign bus_i = oe ? bus_o : dout;
	assign zi = z_oe ? z_o : zero_ext;
	assign wi = w_oe ? w_o : wait_ext;
	host_bus_emulation_master #(.DEPTH(16), .AW(4)) dut (.CORE_CLK_I(clk),
		.RST_I(rst), .EXT_RESET_N_I(ext_n), .HOST_TX_DATA_I(tx_d),
		.HOST_TX_VALID_I(tx_v), .HOST_TX_READY_O(tx_rdy),
		.HOST_RX_DATA_O(rx_d), .HOST_RX_VALID_O(rx_v),
		.HOST_RX_READY_I(rx_rdy), .MUX_ADDR_DATA_BUS_I(bus_i),
		.MUX_ADDR_DATA_BUS_O(bus_o), .MUX_ADDR_DATA_BUS_OE_O(oe),
		.ADDR_HI_O(ahi), .SEL_N_O(sel_n), .ADDR_LATCH_O(ale), .RD_N_O(rd_n),
		.WR_N_O(wr_n), .ACCESS_WAIT_IN_I(wait_n),
		.INTERFACE_CLOCK_OUT_O(ifclk), .AUX_PIN_ZERO_I(zi),
		.AUX_PIN_ZERO_O(z_o), .AUX_PIN_ZERO_OE_O(z_oe), .AUX_PIN_WAIT_I(wi),
		.AUX_PIN_WAIT_O(w_o), .AUX_PIN_WAIT_OE_O(w_oe));
	hbm_periph_model u_periph (.clk_i(clk), .slow_i(slow), .addr_hi_i(ahi),
		.bus_i(bus_i), .dev_oe_i(oe), .sel_n_i(sel_n), .ale_i(ale),
		.rd_n_i(rd_n), .wr_n_i(wr_n), .bus_o(dout), .wait_n_o(wait_n));
	initial forever #5 clk = ~clk;
	// Longest read strobe seen, to prove stretching
	always @(posedge clk) begin
		low_len <= rd_n ? 0 : low_len + 1;
		if (!rd_n && low_len >= max_low)
			max_low <= low_len + 1;
	end
	task automatic check(input string what, input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Valid stays up across bytes so it is never lowered and raised at once
	task automatic cmd(input int n, input logic [7:0] b0, b1 = 0, b2 = 0,
		b3 = 0);
		logic [7:0] b [4];
		b = '{b0, b1, b2, b3};
		for (int i = 0; i < n; i++) begin
			tx_d <= b[i];
			tx_v <= 1'b1;
			do @(posedge clk); while (tx_rdy !== 1'b1);
		end
		tx_v <= 1'b0;
		@(posedge clk);
	endtask
	task automatic get(input string what, input logic [7:0] exp);
		int k = 0;
		while (rx_v !== 1'b1 && k < 300) begin
			@(posedge clk);
			k++;
		end
		if (k == 300)
			miscompares++;
		check(what, rx_d, exp);
		rx_rdy <= 1'b1;
		@(posedge clk);
		rx_rdy <= 1'b0;
	endtask
	task automatic t_rw;
		cmd(4, hbm_pkg::OP_WRITE, 8'h12, 8'h34, 8'ha5);
		cmd(4, hbm_pkg::OP_WRITE, 8'h12, 8'h35, 8'h5a);
		cmd(3, hbm_pkg::OP_READ, 8'h12, 8'h34);
		get("read a", 8'ha5);
		cmd(3, hbm_pkg::OP_READ, 8'h12, 8'h35);
		get("read b", 8'h5a);
		$display("test read_write done");
	endtask
	task automatic t_wait;
		slow <= 1'b1;
		cmd(4, hbm_pkg::OP_WRITE, 8'h77, 8'h99, 8'h3c);
		cmd(3, hbm_pkg::OP_READ, 8'h77, 8'h99);
		get("slow read", 8'h3c);
		check("stretched", {7'h0, max_low >= 5}, 8'h01);
		slow <= 1'b0;
		$display("test wait_stretch done");
	endtask
	task automatic t_aux;
		wait_ext <= 1'b1;
		cmd(2, hbm_pkg::OP_AUX_DIR, 8'h01);
		cmd(2, hbm_pkg::OP_AUX_SET, 8'h01);
		cmd(1, hbm_pkg::OP_AUX_GET);
		get("aux set", 8'h03);
		check("zero oe", {7'h0, z_oe}, 8'h01);
		check("pins out", {6'h0, w_o, z_o}, 8'h01);
		// Unknown opcode must be dropped without eating the next command
		cmd(1, 8'hee);
		cmd(2, hbm_pkg::OP_AUX_SET, 8'h00);
		cmd(1, hbm_pkg::OP_AUX_GET);
		get("aux clear", 8'h02);
		$display("test aux done");
	endtask
	task automatic t_irq;
		wait_ext <= 1'b0;
		cmd(4, hbm_pkg::OP_WRITE, 8'h00, 8'h10, 8'hc3);
		cmd(2, hbm_pkg::OP_AUX_DIR, 8'h03);
		cmd(1, hbm_pkg::OP_WAIT_HI);
		cmd(3, hbm_pkg::OP_READ, 8'h00, 8'h10);
		repeat (40) @(posedge clk);
		check("early result", {7'h0, rx_v}, 8'h00);
		check("wait pin oe", {7'h0, w_oe}, 8'h00);
		wait_ext <= 1'b1;
		get("irq read", 8'hc3);
		cmd(1, hbm_pkg::OP_WAIT_LO);
		cmd(1, hbm_pkg::OP_AUX_GET);
		repeat (40) @(posedge clk);
		check("early level", {7'h0, rx_v}, 8'h00);
		wait_ext <= 1'b0;
		get("low level", 8'h00);
		$display("test wait_level done");
	endtask
	task automatic t_clk;
		int n = 0;
		logic prev;
		prev = ifclk;
		repeat (16) begin
			@(posedge clk);
			if (ifclk !== prev)
				n++;
			prev = ifclk;
		end
		check("clock toggles", n[7:0], 8'h08);
		$display("test clock done");
	endtask
	task automatic t_reset;
		ext_n <= 1'b0;
		repeat (4) @(posedge clk);
		check("sel in reset", {7'h0, sel_n}, 8'h01);
		check("ready in reset", {7'h0, tx_rdy}, 8'h00);
		check("aux oe cleared", {6'h0, w_oe, z_oe}, 8'h00);
		ext_n <= 1'b1;
		repeat (3) @(posedge clk);
		$display("test ext_reset done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence: power-up reset, then each scenario in turn
	initial begin
		repeat (4) @(posedge clk);
		check("ready at power-up", {7'h0, tx_rdy}, 8'h00);
		rst <= 1'b0;
		@(posedge clk);
		t_rw();
		t_wait();
		t_aux();
		t_irq();
		t_clk();
		t_reset();
		tally_and_finish();
	end
	// Watchdog sized well above the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
endmodule

//--- verilog/hbm_pkg.sv
// Shared constants and carriers for the host bus emulation master.
// Assumes one 100 MHz core clock; no software-visible registers.
package hbm_pkg;
	// Command opcodes taken from the host byte stream
	localparam logic [7:0] OP_WRITE = 8'h01; // addr_hi, addr_lo, data
	localparam logic [7:0] OP_READ = 8'h02; // addr_hi, addr_lo
	localparam logic [7:0] OP_AUX_SET = 8'h03; // value byte, bits [1:0]
	localparam logic [7:0] OP_AUX_DIR = 8'h04; // enable byte, bits [1:0]
	localparam logic [7:0] OP_AUX_GET = 8'h05; // returns aux levels
	localparam logic [7:0] OP_WAIT_HI = 8'h06; // stall until aux_pin_wait high
	localparam logic [7:0] OP_WAIT_LO = 8'h07; // stall until aux_pin_wait low
	// Bus phase lengths in core cycles
	localparam int ALE_CYC = 2;
	localparam int STROBE_CYC = 2;
	localparam int SETUP_CYC = 1;
	// Buffer sizing
	localparam int BUF_BYTES = 4096;
	localparam int BUF_AW = 12;
	// Divider for the interface clock output
	localparam int CLKDIV_HALF = 2;
	// Peripheral bus pins as a group
	typedef struct packed {
		logic [7:0] addr_hi;
		logic cs_n;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic [7:0] ad_out;
		logic ad_oe;
	} bus_out_s;
endpackage

//--- verilog/host_bus_emulation_master.sv
// Host bus emulation master: byte stream in, peripheral bus accesses out.
// Assumes a host-side byte stream with valid/ready handshake on CORE_CLK_I.
`timescale 1ns/100ps

// What this block does
// R01 - Both channels act together as one bus master, not two ports.
// R02 - One 8-bit shared bus carries low address and data both ways.
// R03 - Upper address byte driven on its own lines through every access.
// R04 - Active-low select held during read or write, high otherwise.
// R05 - High latch pulse while low address sits on shared bus.
// R06 - Read drives read strobe low, then samples shared bus.
// R07 - Write data stable before write strobe falls until after it rises.
// R08 - Low wait input stretches the current access.
// R09 - Interface clock pin outputs the clock pacing the bus; code outputs a free-running CORE_CLK_I divided by four.
// R10 - Two aux pins settable, clearable and readable by host commands.
// R11 - Commands stall execution until second aux pin high or low.
// R12 - Wait for interrupt level, run queued read, return result.
// R13 - Second aux pin is input-only whenever wait commands are used.
// R14 - Host data stored in a 4 Kbyte transmit buffer.
// R15 - Results held in a 4 Kbyte receive buffer until host reads.
// R16 - Logic resets at power-up and on active-low external reset.
// R17 - Address and latch first, then select with exactly one strobe.
// R18 - Shared bus released during read after the address phase.
module host_bus_emulation_master #(
	parameter int DEPTH = hbm_pkg::BUF_BYTES,
	parameter int AW = hbm_pkg::BUF_AW
) (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic EXT_RESET_N_I,
	// Host side byte stream in
	input wire logic [7:0] HOST_TX_DATA_I,
	input wire logic HOST_TX_VALID_I,
	output logic HOST_TX_READY_O,
	// Host side byte stream out
	output logic [7:0] HOST_RX_DATA_O,
	output logic HOST_RX_VALID_O,
	input wire logic HOST_RX_READY_I,
	// Peripheral bus
	input wire logic [7:0] MUX_ADDR_DATA_BUS_I,
	output logic [7:0] MUX_ADDR_DATA_BUS_O,
	output logic MUX_ADDR_DATA_BUS_OE_O,
	output logic [7:0] ADDR_HI_O,
	output logic SEL_N_O,
	output logic ADDR_LATCH_O,
	output logic RD_N_O,
	output logic WR_N_O,
	input wire logic ACCESS_WAIT_IN_I,
	output logic INTERFACE_CLOCK_OUT_O,
	// Auxiliary pins
	input wire logic AUX_PIN_ZERO_I,
	output logic AUX_PIN_ZERO_O,
	output logic AUX_PIN_ZERO_OE_O,
	input wire logic AUX_PIN_WAIT_I,
	output logic AUX_PIN_WAIT_O,
	output logic AUX_PIN_WAIT_OE_O
);
	typedef enum {
		S_OP, S_ARG0, S_ARG1, S_ARG2, S_WAITPIN, S_ADDR, S_LATCH,
		S_SETUP, S_STROBE, S_HOLD, S_PUSH
	} state_e;

	// Pin synchronisers, two stages each
	logic [3:0] sync1_r, sync2_r;
	logic [7:0] ad_sync1_r, ad_sync2_r;
	logic rst_any, wait_ok, aux_wait_lvl, aux_zero_lvl, ext_rst_n;
	always_ff @(posedge CORE_CLK_I) begin
		sync1_r <= {EXT_RESET_N_I, ACCESS_WAIT_IN_I, AUX_PIN_WAIT_I,
			AUX_PIN_ZERO_I};
		sync2_r <= sync1_r;
		ad_sync1_r <= MUX_ADDR_DATA_BUS_I;
		ad_sync2_r <= ad_sync1_r;
	end
	assign ext_rst_n = sync2_r[3];
	assign wait_ok = sync2_r[2];
	assign aux_wait_lvl = sync2_r[1];
	assign aux_zero_lvl = sync2_r[0];
	// Either reset source clears all control state
	assign rst_any = RST_I | ~ext_rst_n; // R16

	// Transmit buffer: host bytes waiting for the command engine
	logic [7:0] tx_mem [DEPTH];
	logic [AW:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
	logic tx_full, tx_empty, tx_pop;
	logic [7:0] tx_head, rx_din;
	// Receive buffer: read results waiting for the host
	logic [7:0] rx_mem [DEPTH];
	logic [AW:0] rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
	logic rx_full, rx_empty, rx_push;

	function automatic logic is_full(input logic [AW:0] w, input logic [AW:0] r);
		return (w[AW] != r[AW]) && (w[AW-1:0] == r[AW-1:0]);
	endfunction
	assign tx_full = is_full(tx_wp_r, tx_rp_r);
	assign tx_empty = (tx_wp_r == tx_rp_r);
	assign rx_full = is_full(rx_wp_r, rx_rp_r);
	assign rx_empty = (rx_wp_r == rx_rp_r);
	assign HOST_TX_READY_O = ~tx_full & ~rst_any; // R14
	assign tx_head = tx_mem[tx_rp_r[AW-1:0]];
	assign HOST_RX_VALID_O = ~rx_empty;
	assign HOST_RX_DATA_O = rx_mem[rx_rp_r[AW-1:0]]; // R15

	// Buffer pointer next values
	always_comb begin
		tx_wp_nxt = tx_wp_r;
		tx_rp_nxt = tx_rp_r;
		rx_wp_nxt = rx_wp_r;
		rx_rp_nxt = rx_rp_r;
		if (HOST_TX_VALID_I && HOST_TX_READY_O) begin
			tx_wp_nxt = tx_wp_r + 1'b1;
		end
		if (tx_pop) begin
			tx_rp_nxt = tx_rp_r + 1'b1;
		end
		if (rx_push) begin
			rx_wp_nxt = rx_wp_r + 1'b1;
		end
		if (HOST_RX_READY_I && !rx_empty) begin
			rx_rp_nxt = rx_rp_r + 1'b1;
		end
	end

	// Buffer storage and pointers
	always_ff @(posedge CORE_CLK_I) begin
		if (HOST_TX_VALID_I && HOST_TX_READY_O) begin
			tx_mem[tx_wp_r[AW-1:0]] <= HOST_TX_DATA_I; // R14
		end
		if (rx_push) begin
			rx_mem[rx_wp_r[AW-1:0]] <= rx_din; // R15
		end
		if (rst_any) begin
			tx_wp_r <= '0;
			tx_rp_r <= '0;
			rx_wp_r <= '0;
			rx_rp_r <= '0;
		end else begin
			tx_wp_r <= tx_wp_nxt;
			tx_rp_r <= tx_rp_nxt;
			rx_wp_r <= rx_wp_nxt;
			rx_rp_r <= rx_rp_nxt;
		end
	end
	// Command engine and bus sequencer; one engine drives both channels
	state_e st_r, st_nxt; // R01
	logic [7:0] op_r, op_nxt, ahi_r, ahi_nxt;
	logic [7:0] alo_r, alo_nxt, dat_r, dat_nxt;
	logic [1:0] aux_val_r, aux_val_nxt, aux_oe_r, aux_oe_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	hbm_pkg::bus_out_s bus_r, bus_nxt;
	always_comb begin
		st_nxt = st_r;
		op_nxt = op_r;
		ahi_nxt = ahi_r;
		alo_nxt = alo_r;
		dat_nxt = dat_r;
		aux_val_nxt = aux_val_r;
		aux_oe_nxt = aux_oe_r;
		cnt_nxt = cnt_r;
		bus_nxt = bus_r;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_din = dat_r;
		case (st_r)
			S_OP: begin
				if (!tx_empty) begin
					tx_pop = 1'b1;
					op_nxt = tx_head;
					case (tx_head)
						hbm_pkg::OP_AUX_GET: st_nxt = S_PUSH;
						hbm_pkg::OP_WAIT_HI, hbm_pkg::OP_WAIT_LO: begin
							aux_oe_nxt[1] = 1'b0; // R13
							st_nxt = S_WAITPIN;
						end
						hbm_pkg::OP_WRITE, hbm_pkg::OP_READ,
						hbm_pkg::OP_AUX_SET, hbm_pkg::OP_AUX_DIR: st_nxt = S_ARG0;
						default: st_nxt = S_OP;
					endcase
				end
			end
			S_ARG0: begin
				if (!tx_empty) begin
					tx_pop = 1'b1;
					ahi_nxt = tx_head;
					if (op_r == hbm_pkg::OP_AUX_SET) begin
						aux_val_nxt = tx_head[1:0]; // R10
						st_nxt = S_OP;
					end else if (op_r == hbm_pkg::OP_AUX_DIR) begin
						aux_oe_nxt = tx_head[1:0]; // R10
						st_nxt = S_OP;
					end else begin
						st_nxt = S_ARG1;
					end
				end
			end
			S_ARG1: begin
				if (!tx_empty) begin
					tx_pop = 1'b1;
					alo_nxt = tx_head;
					st_nxt = (op_r == hbm_pkg::OP_WRITE) ? S_ARG2 : S_ADDR;
				end
			end
			S_ARG2: begin
				if (!tx_empty) begin
					tx_pop = 1'b1;
					dat_nxt = tx_head;
					st_nxt = S_ADDR;
				end
			end
			S_WAITPIN: begin
				// Following commands, such as a queued read, stall here
				aux_oe_nxt[1] = 1'b0; // R13
				if (aux_wait_lvl == (op_r == hbm_pkg::OP_WAIT_HI)) begin
					st_nxt = S_OP; // R11 R12
				end
			end
			S_ADDR: begin
				// Full address on the pins before any strobe
				bus_nxt.addr_hi = ahi_r; // R03
				bus_nxt.ad_out = alo_r; // R02
				bus_nxt.ad_oe = 1'b1;
				bus_nxt.ale = 1'b1; // R05 R17
				cnt_nxt = 2'(hbm_pkg::ALE_CYC - 1);
				st_nxt = S_LATCH;
			end
			S_LATCH: begin
				if (cnt_r == 2'd0) begin
					bus_nxt.ale = 1'b0;
					bus_nxt.cs_n = 1'b0; // R04
					if (op_r == hbm_pkg::OP_WRITE) begin
						bus_nxt.ad_out = dat_r; // R07
					end else begin
						bus_nxt.ad_oe = 1'b0; // R18
					end
					cnt_nxt = 2'(hbm_pkg::SETUP_CYC - 1);
					st_nxt = S_SETUP;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			S_SETUP: begin
				// Data settles a cycle before the write strobe falls
				if (cnt_r == 2'd0) begin
					bus_nxt.rd_n = (op_r == hbm_pkg::OP_WRITE); // R06 R17
					bus_nxt.wr_n = (op_r != hbm_pkg::OP_WRITE); // R07 R17
					cnt_nxt = 2'(hbm_pkg::STROBE_CYC - 1);
					st_nxt = S_STROBE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			S_STROBE: begin
				if (cnt_r != 2'd0) begin
					cnt_nxt = cnt_r - 1'b1;
				end else if (wait_ok) begin // R08
					dat_nxt = ad_sync2_r; // R06
					bus_nxt.rd_n = 1'b1;
					bus_nxt.wr_n = 1'b1;
					st_nxt = S_HOLD;
				end
			end
			S_HOLD: begin
				// Write data held one cycle past the strobe rise
				bus_nxt.cs_n = 1'b1; // R04
				bus_nxt.ad_oe = 1'b0; // R07
				st_nxt = (op_r == hbm_pkg::OP_READ) ? S_PUSH : S_OP;
			end
			S_PUSH: begin
				rx_din = (op_r == hbm_pkg::OP_AUX_GET) ?
					{6'h00, aux_wait_lvl, aux_zero_lvl} : dat_r; // R10 R12
				if (!rx_full) begin
					rx_push = 1'b1; // R15
					st_nxt = S_OP;
				end
			end
			default: st_nxt = S_OP;
		endcase
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (rst_any) begin
			st_r <= S_OP;
			op_r <= 8'h00;
			ahi_r <= 8'h00;
			alo_r <= 8'h00;
			dat_r <= 8'h00;
			aux_val_r <= 2'h0;
			aux_oe_r <= 2'h0;
			cnt_r <= 2'h0;
			bus_r <= '{addr_hi: 8'h00, cs_n: 1'b1, ale: 1'b0, rd_n: 1'b1,
				wr_n: 1'b1, ad_out: 8'h00, ad_oe: 1'b0};
		end else begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			ahi_r <= ahi_nxt;
			alo_r <= alo_nxt;
			dat_r <= dat_nxt;
			aux_val_r <= aux_val_nxt;
			aux_oe_r <= aux_oe_nxt;
			cnt_r <= cnt_nxt;
			bus_r <= bus_nxt;
		end
	end
	// Interface clock divider, free running from reset
	logic [1:0] div_r, div_nxt;
	logic clko_r, clko_nxt;
	always_comb begin
		div_nxt = div_r + 1'b1;
		clko_nxt = clko_r;
		if (div_r == 2'(hbm_pkg::CLKDIV_HALF - 1)) begin
			div_nxt = 2'h0;
			clko_nxt = ~clko_r; // R09
		end
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (rst_any) begin
			div_r <= 2'h0;
			clko_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			clko_r <= clko_nxt;
		end
	end
	// Pin drivers straight from flip-flops
	assign MUX_ADDR_DATA_BUS_O = bus_r.ad_out;
	assign MUX_ADDR_DATA_BUS_OE_O = bus_r.ad_oe;
	assign ADDR_HI_O = bus_r.addr_hi;
	assign SEL_N_O = bus_r.cs_n;
	assign ADDR_LATCH_O = bus_r.ale;
	assign RD_N_O = bus_r.rd_n;
	assign WR_N_O = bus_r.wr_n;
	assign INTERFACE_CLOCK_OUT_O = clko_r;
	assign AUX_PIN_ZERO_O = aux_val_r[0];
	assign AUX_PIN_ZERO_OE_O = aux_oe_r[0];
	assign AUX_PIN_WAIT_O = aux_val_r[1];
	assign AUX_PIN_WAIT_OE_O = aux_oe_r[1];
endmodule
